// >>> core/tsl_map.svh
// Constants of the serial link timing block: widths, slot ranges, reset values.
// Assumes inclusion by bare name from the package and the link module.
`ifndef TSL_MAP_SVH
`define TSL_MAP_SVH

`define TSL_BYTE_W      8
`define TSL_SLOT_W      7
`define TSL_BIT_W       3
`define TSL_TX_SLOT_PROVISIONED_W   128
`define TSL_RX_SLOT_PROVISIONED_W   32
`define TSL_RX_IDX_W    5
`define TSL_BIT_FIRST   3'h0
`define TSL_BIT_LAST    3'h7
`define TSL_BYTE_MSB    7
`define TSL_CH_FIRST    7'h01
`define TSL_T1_LAST     7'h18
`define TSL_E1_LAST     7'h1F
`define TSL_MV_FIRST    7'h00
`define TSL_HS_LAST     7'h7F
`define TSL_MV2_LAST    7'h1F
`define TSL_SLOT_ONE    7'h01
`define TSL_BYTE_RST    8'h00
`define TSL_TX_SLOT_PROVISIONED_RST 128'h0
`define TSL_RX_SLOT_PROVISIONED_RST 32'h0

`endif

// >>> core/tsl_pkg.sv
// Types shared by the serial link timing block.
// Assumes tsl_map.svh is on the include path.
`include "tsl_map.svh"

package tsl_pkg;

  // Line modes of one port
  typedef enum logic [2:0] {
    TSL_MODE_UNCH,
    TSL_MODE_T1,
    TSL_MODE_E1,
    TSL_MODE_HS,
    TSL_MODE_MV2
  } tsl_mode_t;

  // Transmit configuration, quasi-static
  typedef struct packed {
    tsl_mode_t                   mode;
    logic [`TSL_BYTE_W-1:0]      idleFill;
  } tsl_tx_cfg_t;

  // One received octet with its time-slot
  typedef struct packed {
    logic [`TSL_SLOT_W-1:0]      slot;
    logic [`TSL_BYTE_W-1:0]      data;
  } tsl_rx_word_t;

endpackage

// >>> core/tsl_link.sv
// Serial line port: bit timing of transmit (all modes) and receive (unchannelised, T1 and E1; not H-MVIP).
// Assumes the far side supplies lineTxClock and lineRxClock; both may stop at any time.
// Configuration inputs are quasi-static and change only while the port is idle.
//
// Behaviour
// - High-speed transmit: frame pulse sampled low on falling edge starts next frame.
// - High-speed transmit: data changes every second falling edge; one bit spans two clocks.
// - H-MVIP transmit: first frame bit goes out on the edge sampling the pulse low.
// - H-MVIP transmit octets go out bit one (MSB) first, bit eight last.
// - Channelised transmit: unprovisioned slot carries the idle-fill byte.
// - 2.048 Mbps transmit: group clock and pulse serve eight lines; low pulse starts frame.
// - 2.048 Mbps transmit: a group's line updates on every second falling clock edge.
// - Unchannelised receive: continuous stream, eight bits per byte, first bit MSB.
// - Receive bits captured on rising edge; far side gaps the clock to skip bits.
// - T1 receive: framing bit gapped, first edge after captures slot 1 MSB.
// - E1 receive: framing byte gapped, first edge after captures slot 1 MSB.
// - Channelised receive discards slots whose provision flag is low.
// - Unchannelised transmit: data changes on falling edge, each octet MSB first.
// - Transmit clock may stall anywhere; device holds its current bit meanwhile.
// - T1 transmit: slots 1 to 24 MSB first; slot 24 bit eight precedes framing.
// - E1 transmit: slots 1 to 31 MSB first; slot 31 bit eight precedes framing.
`timescale 1ns/10ps
`include "tsl_map.svh"

module tsl_link (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  // Core side, transmit
  input  wire tsl_pkg::tsl_tx_cfg_t         txCfg,
  input  wire logic [`TSL_TX_SLOT_PROVISIONED_W-1:0]    txSlotProvisioned,
  input  wire logic [`TSL_BYTE_W-1:0]       txByte,
  input  wire logic                         txByteValid,
  output logic                              txByteReady,
  // Core side, receive
  input  wire tsl_pkg::tsl_mode_t           rxMode,
  input  wire logic [`TSL_RX_SLOT_PROVISIONED_W-1:0]    rxSlotProvisioned,
  output tsl_pkg::tsl_rx_word_t             rxWord,
  output logic                              rxWordValid,
  // Transmit line
  input  wire logic                         lineTxClock,
  input  wire logic                         txFramePulseN,
  output logic                              serialTxData,
  // Receive line
  input  wire logic                         lineRxClock,
  input  wire logic                         serialRxData
);

  // ---------------------------------------------------------------------------
  // Core domain: transmit holding byte, handed over by toggle handshake
  // ---------------------------------------------------------------------------
  logic                       txPutT;
  logic [`TSL_BYTE_W-1:0]     txHold;
  logic                       txTakeT;
  logic                       txTakeM;
  logic                       txTakeS;
  logic                       txLoad;
  logic                       next_txPutT;

  // Holding byte is free when the link side has taken the last one
  assign txLoad      = txByteValid && txByteReady;
  assign next_txPutT = txPutT ^ txLoad;

  // Take toggle from the link domain, two flops
  always_ff @(posedge core_clk) begin
    txTakeM <= txTakeT;
    txTakeS <= txTakeM;
  end

  // Holding byte stays still until the link domain has acknowledged it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txPutT      <= 1'b0;
      txHold      <= `TSL_BYTE_RST;
      txByteReady <= 1'b0;
    end else begin
      if (txLoad) begin
        txHold <= txByte;
      end
      txPutT      <= next_txPutT;
      txByteReady <= (txTakeS == next_txPutT);
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit link domain, falling edge of lineTxClock
  // ---------------------------------------------------------------------------
  logic                       txRstM;
  logic                       txRst;
  logic                       txPutM;
  logic                       txPutS;
  tsl_pkg::tsl_tx_cfg_t       txCfgM;
  tsl_pkg::tsl_tx_cfg_t       txCfgS;
  logic [`TSL_TX_SLOT_PROVISIONED_W-1:0]  txProvM;
  logic [`TSL_TX_SLOT_PROVISIONED_W-1:0]  txProvS;

  // Reset, configuration and put toggle cross on two flops each
  always_ff @(negedge lineTxClock) begin
    txRstM  <= sys_rst;
    txRst   <= txRstM;
    txPutM  <= txPutT;
    txPutS  <= txPutM;
    txCfgM  <= txCfg;
    txCfgS  <= txCfgM;
    txProvM <= txSlotProvisioned;
    txProvS <= txProvM;
  end

  logic [`TSL_SLOT_W-1:0]     txSlot;
  logic [`TSL_BIT_W-1:0]      txBit;
  logic [`TSL_BYTE_W-1:0]     txShift;
  logic                       txHoldNext;
  logic                       txHmvip;
  logic                       txChan;
  logic                       txFrameHit;
  logic                       txByteEnd;
  logic                       txAvail;
  logic [`TSL_SLOT_W-1:0]     txFirst;
  logic [`TSL_SLOT_W-1:0]     txLast;
  logic [`TSL_SLOT_W-1:0]     txNextSlot;
  logic [`TSL_SLOT_W-1:0]     txFetchSlot;
  logic                       txFetchProv;
  logic [`TSL_BYTE_W-1:0]     txFetchByte;
  logic                       txFetchTake;
  logic                       txFetch;

  // Mode decode
  assign txHmvip = (txCfgS.mode == tsl_pkg::TSL_MODE_HS) ||
                   (txCfgS.mode == tsl_pkg::TSL_MODE_MV2);
  assign txChan  = (txCfgS.mode != tsl_pkg::TSL_MODE_UNCH);

  // Slot range per mode; clock gaps of the framing bit or byte need no count
  assign txFirst = txHmvip ? `TSL_MV_FIRST : `TSL_CH_FIRST;
  assign txLast  = (txCfgS.mode == tsl_pkg::TSL_MODE_T1)  ? `TSL_T1_LAST :
                   (txCfgS.mode == tsl_pkg::TSL_MODE_E1)  ? `TSL_E1_LAST :
                   (txCfgS.mode == tsl_pkg::TSL_MODE_HS)  ? `TSL_HS_LAST :
                   (txCfgS.mode == tsl_pkg::TSL_MODE_MV2) ? `TSL_MV2_LAST :
                   `TSL_CH_FIRST;
  assign txNextSlot = (txSlot >= txLast) ? txFirst : txSlot + `TSL_SLOT_ONE;

  // Frame pulse is sampled on the data clock fall that the far side aligns
  assign txFrameHit = txHmvip && !txFramePulseN;
  assign txByteEnd  = (txBit == `TSL_BIT_LAST);
  // In H-MVIP modes every other edge only holds the line
  assign txFetch    = txFrameHit || (!txHoldNext && txByteEnd);

  // Byte for the slot about to start: frame start restarts at slot zero
  assign txFetchSlot = txFrameHit ? `TSL_MV_FIRST : txNextSlot;
  assign txFetchProv = !txChan || txProvS[txFetchSlot];
  assign txAvail     = (txPutS != txTakeT);
  // Unprovisioned slots and starved slots both send the idle byte
  assign txFetchByte = (txFetchProv && txAvail) ? txHold : txCfgS.idleFill;
  assign txFetchTake = txFetch && txFetchProv && txAvail;

  // Bit engine; with no clock edge nothing moves, so a stalled line holds its bit
  always_ff @(negedge lineTxClock) begin
    if (txRst) begin
      txSlot       <= `TSL_HS_LAST;
      txBit        <= `TSL_BIT_LAST;
      txShift      <= `TSL_BYTE_RST;
      txHoldNext   <= 1'b0;
      txTakeT      <= 1'b0;
      serialTxData <= 1'b0;
    end else if (txFetch) begin
      txSlot       <= txFetchSlot;
      txBit        <= `TSL_BIT_FIRST;
      txShift      <= txFetchByte;
      txHoldNext   <= txHmvip;
      txTakeT      <= txTakeT ^ txFetchTake;
      serialTxData <= txFetchByte[`TSL_BYTE_MSB];
    end else if (txHoldNext) begin
      txHoldNext   <= 1'b0;
    end else begin
      txBit        <= txBit + `TSL_BIT_W'(1);
      txShift      <= {txShift[`TSL_BYTE_MSB-1:0], 1'b0};
      txHoldNext   <= txHmvip;
      serialTxData <= txShift[`TSL_BYTE_MSB-1];
    end
  end

  // ---------------------------------------------------------------------------
  // Receive link domain, rising edge of lineRxClock
  // ---------------------------------------------------------------------------
  logic                       rxRstM;
  logic                       rxRst;
  tsl_pkg::tsl_mode_t         rxModeM;
  tsl_pkg::tsl_mode_t         rxModeS;
  logic [`TSL_RX_SLOT_PROVISIONED_W-1:0]  rxProvM;
  logic [`TSL_RX_SLOT_PROVISIONED_W-1:0]  rxProvS;

  // Reset and configuration cross on two flops each
  always_ff @(posedge lineRxClock) begin
    rxRstM  <= sys_rst;
    rxRst   <= rxRstM;
    rxModeM <= rxMode;
    rxModeS <= rxModeM;
    rxProvM <= rxSlotProvisioned;
    rxProvS <= rxProvM;
  end

  logic [`TSL_SLOT_W-1:0]     rxSlot;
  logic [`TSL_BIT_W-1:0]      rxBit;
  logic [`TSL_BYTE_W-1:0]     rxShift;
  logic [`TSL_BYTE_W-1:0]     rxFull;
  logic                       rxByteEnd;
  logic                       rxUnch;
  logic                       rxChan;
  logic [`TSL_SLOT_W-1:0]     rxLast;
  logic [`TSL_SLOT_W-1:0]     rxNextSlot;
  logic                       rxKeep;
  tsl_pkg::tsl_rx_word_t      rxHold;
  logic                       rxPutT;

  // Mode decode; H-MVIP receive is not handled here, its bits are dropped
  assign rxUnch = (rxModeS == tsl_pkg::TSL_MODE_UNCH);
  assign rxChan = (rxModeS == tsl_pkg::TSL_MODE_T1) || (rxModeS == tsl_pkg::TSL_MODE_E1);
  // Slot count relies on an ungapped clock inside the slots
  assign rxLast = (rxModeS == tsl_pkg::TSL_MODE_T1) ? `TSL_T1_LAST : `TSL_E1_LAST;
  assign rxNextSlot = (rxSlot >= rxLast) ? `TSL_CH_FIRST : rxSlot + `TSL_SLOT_ONE;

  // First received bit lands in the MSB
  assign rxFull    = {rxShift[`TSL_BYTE_MSB-1:0], serialRxData};
  assign rxByteEnd = (rxBit == `TSL_BIT_LAST);
  assign rxKeep    = rxUnch || (rxChan && rxProvS[rxSlot[`TSL_RX_IDX_W-1:0]]);

  // Capture on every rising edge; skipped bits simply bring no edge
  always_ff @(posedge lineRxClock) begin
    if (rxRst) begin
      rxSlot  <= `TSL_CH_FIRST;
      rxBit   <= `TSL_BIT_FIRST;
      rxShift <= `TSL_BYTE_RST;
      rxHold  <= '0;
      rxPutT  <= 1'b0;
    end else begin
      rxShift <= rxFull;
      rxBit   <= rxBit + `TSL_BIT_W'(1);
      if (rxByteEnd) begin
        rxSlot <= rxNextSlot;
        if (rxKeep) begin
          rxHold.slot <= rxUnch ? `TSL_MV_FIRST : rxSlot;
          rxHold.data <= rxFull;
          rxPutT      <= ~rxPutT;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Core domain: receive word handed over by toggle; rxHold is stable for
  // eight link bits, far longer than the three core cycles this takes
  // ---------------------------------------------------------------------------
  logic                       rxPutM;
  logic                       rxPutS;
  logic                       rxSeen;
  logic                       rxNew;

  assign rxNew = (rxPutS != rxSeen);

  // Put toggle from the receive domain, two flops
  always_ff @(posedge core_clk) begin
    rxPutM <= rxPutT;
    rxPutS <= rxPutM;
  end

  // One-cycle valid pulse per octet
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxSeen      <= 1'b0;
      rxWord      <= '0;
      rxWordValid <= 1'b0;
    end else begin
      rxSeen      <= rxPutS;
      rxWordValid <= rxNew;
      if (rxNew) begin
        rxWord <= rxHold;
      end
    end
  end

endmodule

// >>> tb/tsl_link_checker.sv
// Timing checker for the serial link port, bound to every tsl_link instance.
// Assumes configuration changes only while sys_rst is high.
`timescale 1ns/10ps
`include "tsl_map.svh"
module tsl_link_checker (
  input wire logic                      core_clk,
  input wire logic                      sys_rst,
  input wire tsl_pkg::tsl_tx_cfg_t      txCfg,
  input wire logic [`TSL_TX_SLOT_PROVISIONED_W-1:0] txSlotProvisioned,
  input wire logic [`TSL_BYTE_W-1:0]    txByte,
  input wire logic                      txByteValid,
  input wire logic                      txByteReady,
  input wire tsl_pkg::tsl_mode_t        rxMode,
  input wire logic [`TSL_RX_SLOT_PROVISIONED_W-1:0] rxSlotProvisioned,
  input wire tsl_pkg::tsl_rx_word_t     rxWord,
  input wire logic                      rxWordValid,
  input wire logic                      lineTxClock,
  input wire logic                      txFramePulseN,
  input wire logic                      serialTxData,
  input wire logic                      lineRxClock,
  input wire logic                      serialRxData
);
  // Mode decodes; slot contents are judged on the wire by the bench
  wire hvMode = txCfg.mode inside {tsl_pkg::TSL_MODE_HS, tsl_pkg::TSL_MODE_MV2};
  wire rxHv   = rxMode inside {tsl_pkg::TSL_MODE_HS, tsl_pkg::TSL_MODE_MV2};
  wire rxChan = rxMode inside {tsl_pkg::TSL_MODE_T1, tsl_pkg::TSL_MODE_E1};
  sequence takeS;
    txByteValid && txByteReady;
  endsequence
  // A bit update that was not a frame restart must be followed by a hold
  sequence hvUpdateS;
    hvMode && $changed(serialTxData) && txFramePulseN;
  endsequence
  ready_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    takeS |=> !txByteReady) else $error("ready held after a take");
  rst_quiet_a: assert property (@(posedge core_clk)
    sys_rst |=> !txByteReady && !rxWordValid) else $error("outputs active in reset");
  rx_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxWordValid |=> !rxWordValid) else $error("word valid longer than a cycle");
  unch_slot_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxWordValid && rxMode == tsl_pkg::TSL_MODE_UNCH |-> rxWord.slot == 7'h00)
    else $error("plain word carries a slot");
  t1_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxWordValid && rxMode == tsl_pkg::TSL_MODE_T1 |-> rxWord.slot inside {[7'h01:7'h18]})
    else $error("T1 slot out of range");
  e1_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxWordValid && rxMode == tsl_pkg::TSL_MODE_E1 |-> rxWord.slot inside {[7'h01:7'h1F]})
    else $error("E1 slot out of range");
  rx_slot_provisioned_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxWordValid && rxChan |-> rxSlotProvisioned[rxWord.slot[4:0]])
    else $error("unprovisioned slot delivered");
  hv_rx_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rxHv |-> !rxWordValid) else $error("word delivered in H-MVIP receive");
  tx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $stable(lineTxClock) |-> $stable(serialTxData)) else $error("data moved without a clock");
  hv_half_a: assert property (@(negedge lineTxClock) disable iff (sys_rst)
    hvUpdateS |=> $stable(serialTxData)) else $error("H-MVIP bit shorter than two clocks");
endmodule

bind tsl_link tsl_link_checker tsl_link_checker_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .txCfg(txCfg), .txByte(txByte),
  .txSlotProvisioned(txSlotProvisioned), .txByteValid(txByteValid), .rxMode(rxMode),
  .txByteReady(txByteReady), .rxSlotProvisioned(rxSlotProvisioned), .rxWord(rxWord),
  .rxWordValid(rxWordValid), .lineTxClock(lineTxClock), .txFramePulseN(txFramePulseN),
  .serialTxData(serialTxData), .lineRxClock(lineRxClock), .serialRxData(serialRxData));

// >>> tb/tsl_far_end.sv
// Far-end framer model: one gated 48 ns link clock for both directions, pulse, rx data.
// Assumes the port's link domains leave reset two link-clock edges after sys_rst.
`timescale 1ns/10ps
module tsl_far_end (
  input  wire logic               sys_rst,
  input  wire tsl_pkg::tsl_mode_t mode,
  input  wire logic               serialTxData,
  output logic                    lineTxClock,
  output logic                    lineRxClock,
  output logic                    txFramePulseN,
  output logic                    serialRxData,
  output logic [15:0]             frameWord,
  output logic [15:0]             frameCount,
  output logic [15:0]             txEdges,
  output logic [31:0]             txHist
);
  logic       tick = 1'b0;
  logic [2:0] rstSeen = 3'h7;
  logic [8:0] pos = 9'h000;
  logic [7:0] bitNo = 8'h00;
  wire  t1 = mode == tsl_pkg::TSL_MODE_T1;
  wire  e1 = mode == tsl_pkg::TSL_MODE_E1;
  wire  un = mode == tsl_pkg::TSL_MODE_UNCH;
  wire  hv = !(t1 || e1 || un);
  // Framing gaps (T1 one bit, E1 eight) and plain-mode stalls hold the clock low
  function automatic logic isGap(input logic [8:0] p);
    return (t1 && p == 9'h0C0) || (e1 && p >= 9'h0F8) || (un && p == 9'h006);
  endfunction
  wire [8:0] frameLen = t1 ? 9'h0C1 : e1 ? 9'h100 : un ? 9'h007 : 9'h020;
  wire [8:0] lastPos  = t1 ? 9'h0BF : e1 ? 9'h0F7 : un ? 9'h1FF : 9'h01F;
  wire [8:0] nextPos  = (rstSeen[2] || pos == frameLen - 9'h001) ? 9'h000 : pos + 9'h001;
  wire [7:0] emitNo   = rstSeen[2] ? 8'h00 : bitNo;
  // Each byte carries its slot or byte number, so a shifted frame cannot pass
  wire [7:0] rxByte   = un ? {emitNo[7:3], 3'h5} : {nextPos[7:3] + 5'h01, 3'h5};
  assign lineTxClock = tick & ~isGap(pos);
  assign lineRxClock = tick & ~isGap(pos);
  initial begin
    txFramePulseN = 1'b1;
    serialRxData = 1'b0;
    frameCount = 16'h0000;
    txEdges = 16'h0000;
    txHist = 32'h0000_0000;
    frameWord = 16'h0000;
    #7;
    forever #24 tick = ~tick;
  end
  // Receive data moves on the fall, away from the capturing rise; gaps toggle the line
  always @(negedge tick) begin
    pos <= nextPos;
    serialRxData <= isGap(nextPos) ? ~serialRxData : rxByte[~(un ? emitNo[2:0] : nextPos[2:0])];
    bitNo <= emitNo + {7'h00, !isGap(nextPos)};
  end
  // Pulse changes on the rise so it is steady across the data clock fall that samples it
  always @(posedge tick) begin
    rstSeen <= {rstSeen[1:0], sys_rst};
    txFramePulseN <= !(hv && pos == 9'h000);
  end
  // H-MVIP bits last two clocks, so only odd periods after the pulse are taken
  always @(posedge lineTxClock) begin
    if (!hv || pos[0]) begin
      txHist <= {txHist[30:0], serialTxData};
      txEdges <= txEdges + 16'h0001;
    end
    if (pos == lastPos) begin
      frameWord <= {txHist[14:0], serialTxData};
      frameCount <= frameCount + 16'h0001;
    end
  end
endmodule

// >>> tb/test_tsl_link.sv
// Self-checking bench for tsl_link against the far-end framer model.
// Assumes mode changes only under reset; each scenario reconfigures and resets.
`timescale 1ns/10ps
`include "tsl_map.svh"
module test_tsl_link;
  logic                      core_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  tsl_pkg::tsl_tx_cfg_t      txCfg;
  logic [`TSL_TX_SLOT_PROVISIONED_W-1:0] txProv;
  logic [`TSL_RX_SLOT_PROVISIONED_W-1:0] rxProv;
  logic [`TSL_BYTE_W-1:0]    txByte;
  logic                      txByteValid, txByteReady, rxWordValid, serialTxData;
  tsl_pkg::tsl_rx_word_t     rxWord;
  logic                      lineTxClock, lineRxClock, txFramePulseN, serialRxData;
  logic [15:0]               frameWord, frameCount, txEdges;
  logic [31:0]               txHist;
  int                        errors = 0;
  int                        comparisons = 0;
  always #2 core_clk = ~core_clk;
  tsl_link tsl_link_i (.core_clk(core_clk), .sys_rst(sys_rst), .txCfg(txCfg),
    .txSlotProvisioned(txProv), .txByte(txByte), .txByteValid(txByteValid),
    .txByteReady(txByteReady), .rxMode(txCfg.mode), .rxSlotProvisioned(rxProv),
    .rxWord(rxWord), .rxWordValid(rxWordValid), .lineTxClock(lineTxClock),
    .txFramePulseN(txFramePulseN), .serialTxData(serialTxData),
    .lineRxClock(lineRxClock), .serialRxData(serialRxData));
  tsl_far_end tsl_far_end_i (.sys_rst(sys_rst), .mode(txCfg.mode), .serialTxData(serialTxData),
    .lineTxClock(lineTxClock), .lineRxClock(lineRxClock), .txFramePulseN(txFramePulseN),
    .serialRxData(serialRxData), .frameWord(frameWord), .frameCount(frameCount),
    .txEdges(txEdges), .txHist(txHist));
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic expect16(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Reset outlasts any framing gap plus three link edges; release just after a link rise
  // so both link domains and the far end leave reset in one fixed phase
  task automatic setup(input tsl_pkg::tsl_mode_t m, input logic [127:0] tp, input logic [31:0] rp);
    sys_rst = 1'b1;
    txCfg.mode = m;
    txProv = tp;
    rxProv = rp;
    repeat (200) @(negedge core_clk);
    @(posedge lineTxClock);
    @(negedge core_clk);
    sys_rst = 1'b0;
  endtask
  task automatic waitReady();
    for (int n = 0; n < 20000 && txByteReady !== 1'b1; n++) @(negedge core_clk);
  endtask
  task automatic send(input logic [7:0] b);
    waitReady();
    txByte = b;
    txByteValid = 1'b1;
    @(negedge core_clk);
    txByteValid = 1'b0;
  endtask
  task automatic waitFrame();
    logic [15:0] c;
    c = frameCount;
    for (int n = 0; n < 20000 && frameCount === c; n++) @(negedge core_clk);
  endtask
  // One provisioned slot: filled once, then starved so it falls back to idle fill
  task automatic txFrame(input tsl_pkg::tsl_mode_t m, input int slot, input logic [15:0] exp);
    setup(m, 128'h1 << slot, 32'h0000_0000);
    waitFrame();
    send(8'hC3);
    waitReady();
    waitFrame();
    expect16(exp, frameWord);
    waitFrame();
    expect16(16'h5A5A, frameWord);
  endtask
  // Two bytes back to back through a stalling clock must appear whole and in order
  task automatic unchTx();
    logic [15:0] e;
    logic        hit;
    setup(tsl_pkg::TSL_MODE_UNCH, 128'h0, 32'h0000_0000);
    send(8'hE1);
    send(8'h0F);
    waitReady();
    e = txEdges;
    for (int n = 0; n < 2000 && txEdges - e < 16'h0014; n++) @(negedge core_clk);
    hit = 1'b0;
    for (int i = 0; i <= 16; i++) hit = hit | (txHist[i +: 16] === 16'hE10F);
    expect16(16'h0001, {15'h0000, hit});
  endtask
  // Channelised bytes carry their slot number; plain-mode bytes count up by eight
  task automatic rxCheck(input tsl_pkg::tsl_mode_t m, input logic [31:0] rp,
                         input logic [31:0] slots);
    logic [7:0] prev;
    logic [7:0] s;
    logic [7:0] e;
    setup(m, 128'h0, rp);
    prev = 8'h00;
    for (int i = 0; i < 4; i++) begin
      for (int n = 0; n < 20000 && rxWordValid !== 1'b1; n++) @(negedge core_clk);
      s = slots[31 - 8 * i -: 8];
      e = (i == 0) ? {rxWord.data[7:3], 3'h5} : prev + 8'h08;
      expect16({1'b0, (m == tsl_pkg::TSL_MODE_UNCH) ? {7'h00, e} : {s[6:0], s[4:0], 3'h5}},
               {1'b0, rxWord});
      prev = rxWord.data;
      @(negedge core_clk);
    end
  endtask
  initial begin
    txCfg = '{mode: tsl_pkg::TSL_MODE_UNCH, idleFill: 8'h5A};
    txProv = 128'h0;
    rxProv = 32'h0000_0000;
    txByte = 8'h00;
    txByteValid = 1'b0;
    repeat (5) @(negedge core_clk);
    unchTx();
    txFrame(tsl_pkg::TSL_MODE_T1, 24, 16'h5AC3);
    txFrame(tsl_pkg::TSL_MODE_E1, 31, 16'h5AC3);
    txFrame(tsl_pkg::TSL_MODE_HS, 0, 16'hC35A);
    txFrame(tsl_pkg::TSL_MODE_MV2, 0, 16'hC35A);
    rxCheck(tsl_pkg::TSL_MODE_UNCH, 32'h0000_0000, 32'h0000_0000);
    rxCheck(tsl_pkg::TSL_MODE_T1, 32'h0100_0006, 32'h0102_1801);
    rxCheck(tsl_pkg::TSL_MODE_E1, 32'h8000_0006, 32'h0102_1F01);
    conclude();
  end
  // The run needs roughly 110 us; far past that something hangs
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule
